// ---- design/boot_supervisor.sv ----
// Boot entry, watchdog, LED and battery power supervisor
// Function
// - After reset, choose bootloader or normal run
// - Orange while waiting, blue once upload starts
// - Write 0xff to 0x6b reg 0x00 requests boot
// - During upload: blue lit, status LED blinks
// - Read 0x69 reg 0x26 returns firmware version
// - Reset/shutdown key sequence enters bootloader
// - 32 s watchdog returns idle bootloader to run
// - Host monitoring active: steady 400 ms blink
// - Host booting: status LED continuously lit
// - Cable power and monitoring: about 2.5 blinks/s
// - On battery: blink once every 2 s
// - 60 s on battery forces safe shutdown
// - Cable return after shutdown powers host again
// - Toggle on without cable: power host, 2 s blink
// - Toggle off: steady LED, shutdown, drop battery
// - No battery backup while bootloader runs
// - Pulse train out, reply in, shutdown same line
// - Back to cable after 3 s stable supply
module boot_supervisor
   import boot_supervisor_pkg::*;
#(
   parameter int unsigned TICK_DIV = boot_supervisor_pkg::TICK_CYC,
   parameter int unsigned WDOG_TICKS = boot_supervisor_pkg::WDOG_MS,
   parameter int unsigned BATT_TICKS = boot_supervisor_pkg::BATT_RUN_MS,
   parameter int unsigned STABLE_TICKS = boot_supervisor_pkg::CABLE_STABLE_MS,
   parameter int unsigned SHDN_TICKS = boot_supervisor_pkg::SHDN_MS,
   parameter int unsigned REPLY_TICKS = boot_supervisor_pkg::REPLY_TMO_MS,
   parameter logic [7:0] FW_VERSION = boot_supervisor_pkg::FW_VERSION_DEF
) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_cmd_wr,
   input wire logic i_cmd_rd,
   input wire logic [6:0] i_cmd_target,
   input wire logic [7:0] i_cmd_reg,
   input wire logic [7:0] i_cmd_wdata,
   output logic o_cmd_rvalid,
   output logic [7:0] o_cmd_rdata,
   input wire logic i_reset_key,
   input wire logic i_shutdown_key,
   input wire logic i_upload_active,
   input wire logic i_upload_done,
   input wire logic i_cable_ok,
   input wire logic i_toggle_cfg,
   input wire logic i_power_toggle,
   input wire logic i_host_reply,
   output logic o_host_pulse,
   output logic o_host_pwr_en,
   output logic o_batt_en,
   output logic o_led_orange,
   output logic o_led_blue,
   output logic o_led_status,
   output logic o_boot_mode
);
   import boot_supervisor_pkg::*;

   typedef struct packed {
      mode_t mode;
      key_t key;
      logic [TMR_W-1:0] tmr;
      logic [TMR_W-1:0] stab;
      logic [TMR_W-1:0] rply;
      logic [TMR_W-1:0] blink;
      logic [TMR_W-1:0] pcnt;
      logic led_st;
      logic pulse;
      logic batt_sel;
      logic tog_mode;
      logic tog_prev;
      logic boot_req;
      logic reply_prev;
      logic host_pwr;
      logic led_or;
      logic led_bl;
      logic mon;
      logic rvalid;
      logic [7:0] rdata;
   } state_t;

   state_t q, d;
   logic tick;

   ms_tick_gen #(
      .DIV(TICK_DIV)
   ) u_tick (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .o_tick(tick)
   );

   // Saturating tick counter
   function automatic logic [TMR_W-1:0] tick_inc(input logic [TMR_W-1:0] v, input logic t);
      if (t && v != {TMR_W{1'b1}}) begin
         tick_inc = v + TMR_W'(1);
      end else begin
         tick_inc = v;
      end
   endfunction : tick_inc

   logic boot_cmd;
   logic key_req;
   logic cable_stable;
   logic [TMR_W-1:0] half_blink;

   assign boot_cmd = i_cmd_wr && i_cmd_target == CMD_TARGET &&
                     i_cmd_reg == CMD_BOOT_REG && i_cmd_wdata == CMD_BOOT_VAL;
   assign cable_stable = i_cable_ok && q.stab >= TMR_W'(STABLE_TICKS);

   always_comb begin
      d = q;
      key_req = 1'b0;
      half_blink = TMR_W'(BLINK_CABLE_MS / 2);

      // Version read answers one cycle after the request
      d.rvalid = 1'b0;
      if (i_cmd_rd && i_cmd_target == STAT_TARGET && i_cmd_reg == STAT_FW_REG) begin
         d.rvalid = 1'b1;
         d.rdata = FW_VERSION;
      end

      // Key sequence: reset held, add shutdown, drop reset, drop shutdown
      // Any out-of-order move drops back to idle and must start over
      unique case (q.key)
         K_IDLE: begin
            if (i_reset_key && !i_shutdown_key) begin
               d.key = K_RST;
            end
         end
         K_RST: begin
            if (!i_reset_key) begin
               d.key = K_IDLE;
            end else if (i_shutdown_key) begin
               d.key = K_BOTH;
            end
         end
         K_BOTH: begin
            if (!i_shutdown_key) begin
               d.key = K_IDLE;
            end else if (!i_reset_key) begin
               d.key = K_SHUT;
            end
         end
         K_SHUT: begin
            if (i_reset_key) begin
               d.key = K_IDLE;
            end else if (!i_shutdown_key) begin
               d.key = K_IDLE;
               key_req = 1'b1;
            end
         end
      endcase

      // Cable stability, restarted by any dropout
      if (!i_cable_ok) begin
         d.stab = '0;
      end else begin
         d.stab = tick_inc(q.stab, tick);
      end

      // Host reply watch: any reply edge proves the daemon is alive
      // The reply timeout must exceed the pulse half period, or monitoring flaps
      d.reply_prev = i_host_reply;
      if (!q.host_pwr) begin
         d.mon = 1'b0;
         d.rply = '0;
      end else if (i_host_reply != q.reply_prev) begin
         d.rply = '0;
         d.mon = 1'b1;
      end else begin
         d.rply = tick_inc(q.rply, tick);
         if (q.rply >= TMR_W'(REPLY_TICKS)) begin
            d.mon = 1'b0;
         end
      end

      // Pulse train toward the host while it is powered
      // Held high in shutdown, which the host takes as its request
      if (q.mode == M_SHDN) begin
         d.pulse = 1'b1;
         d.pcnt = '0;
      end else if (!q.host_pwr) begin
         d.pulse = 1'b0;
         d.pcnt = '0;
      end else if (tick) begin
         if (q.pcnt >= TMR_W'(PULSE_HALF_MS - 1)) begin
            d.pcnt = '0;
            d.pulse = !q.pulse;
         end else begin
            d.pcnt = q.pcnt + TMR_W'(1);
         end
      end

      d.tog_prev = i_power_toggle;

      unique case (q.mode)
         M_CHECK: begin
            // Host power is kept, so an upload does not cut the host off
            d.tmr = '0;
            d.batt_sel = 1'b0;
            if (q.boot_req) begin
               d.mode = M_BOOT_WAIT;
               d.led_or = 1'b1;
               d.led_bl = 1'b0;
            end else if (i_cable_ok) begin
               d.mode = M_RUN;
               d.host_pwr = 1'b1;
               d.tog_mode = 1'b0;
            end else begin
               d.mode = M_OFF;
               d.host_pwr = 1'b0;
            end
         end
         M_BOOT_WAIT: begin
            // The watchdog runs only while waiting; a started upload is never cut
            d.batt_sel = 1'b0;
            d.tmr = tick_inc(q.tmr, tick);
            if (i_upload_active) begin
               d.mode = M_BOOT_LOAD;
               d.led_or = 1'b0;
               d.led_bl = 1'b1;
            end else if (q.tmr >= TMR_W'(WDOG_TICKS)) begin
               d.boot_req = 1'b0;
               d.led_or = 1'b0;
               d.mode = M_CHECK;
            end
         end
         M_BOOT_LOAD: begin
            d.batt_sel = 1'b0;
            d.led_bl = 1'b1;
            if (i_upload_done) begin
               d.boot_req = 1'b0;
               d.led_bl = 1'b0;
               d.mode = M_CHECK;
            end
         end
         M_OFF: begin
            d.host_pwr = 1'b0;
            d.batt_sel = 1'b0;
            d.tmr = '0;
            if (i_cable_ok) begin
               d.mode = M_RUN;
               d.host_pwr = 1'b1;
               d.tog_mode = 1'b0;
            end else if (i_toggle_cfg && i_power_toggle && !q.tog_prev) begin
               // A toggle left on from before needs a fresh off-to-on move
               d.mode = M_RUN;
               d.host_pwr = 1'b1;
               d.batt_sel = 1'b1;
               d.tog_mode = 1'b1;
            end
         end
         M_RUN: begin
            d.host_pwr = 1'b1;
            if (!i_cable_ok) begin
               d.batt_sel = 1'b1;
            end else if (q.batt_sel && cable_stable) begin
               d.batt_sel = 1'b0;
            end
            if (q.tog_mode && i_toggle_cfg && !i_power_toggle) begin
               d.mode = M_SHDN;
               d.tmr = '0;
            end else if (q.batt_sel && !q.tog_mode && !i_cable_ok) begin
               // A returning supply cancels the countdown even before it is stable
               d.tmr = tick_inc(q.tmr, tick);
               if (q.tmr >= TMR_W'(BATT_TICKS)) begin
                  d.mode = M_SHDN;
                  d.tmr = '0;
               end
            end else begin
               d.tmr = '0;
            end
         end
         M_SHDN: begin
            // Host stays fed while its file systems settle
            d.tmr = tick_inc(q.tmr, tick);
            if (q.tmr >= TMR_W'(SHDN_TICKS)) begin
               d.mode = M_OFF;
               d.host_pwr = 1'b0;
               d.batt_sel = 1'b0;
               d.tog_mode = 1'b0;
            end
         end
         default: begin
            d.mode = M_CHECK;
         end
      endcase

      // Boot request, from the bus or the keys, restarts into the check
      // Refused while already in the bootloader so a repeat cannot restart it
      if ((boot_cmd || key_req) && q.mode != M_BOOT_WAIT && q.mode != M_BOOT_LOAD) begin
         d.boot_req = 1'b1;
         d.mode = M_CHECK;
      end

      // Status LED pattern
      // In run mode without live replies the light stays steady, as while the host boots
      if (q.mode == M_BOOT_LOAD) begin
         half_blink = TMR_W'(BLINK_LOAD_MS / 2);
      end else if (q.batt_sel) begin
         half_blink = TMR_W'(BLINK_BATT_MS / 2);
      end
      if (q.mode == M_SHDN || (q.mode == M_RUN && !q.mon)) begin
         d.led_st = 1'b1;
         d.blink = '0;
      end else if (q.mode == M_BOOT_LOAD || q.mode == M_RUN) begin
         if (tick) begin
            if (q.blink >= half_blink - TMR_W'(1)) begin
               d.blink = '0;
               d.led_st = !q.led_st;
            end else begin
               d.blink = q.blink + TMR_W'(1);
            end
         end
      end else begin
         d.led_st = 1'b0;
         d.blink = '0;
      end
   end

   // Reset lands in the power-on check with the host unpowered
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_cmd_rvalid = q.rvalid;
   assign o_cmd_rdata = q.rdata;
   assign o_host_pulse = q.pulse;
   assign o_host_pwr_en = q.host_pwr;
   assign o_batt_en = q.batt_sel;
   assign o_led_orange = q.led_or;
   assign o_led_blue = q.led_bl;
   assign o_led_status = q.led_st;
   assign o_boot_mode = q.mode == M_BOOT_WAIT || q.mode == M_BOOT_LOAD;
endmodule : boot_supervisor

// ---- design/boot_supervisor_pkg.sv ----
// Shared constants and types for the boot entry and power supervisor
package boot_supervisor_pkg;
   // Clock and base tick
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned TICK_NS = 1000000;
   localparam int unsigned TICK_CYC = TICK_NS / CLK_PERIOD_NS;
   // Timing, in milliseconds (counted on the 1 ms tick)
   localparam int unsigned WDOG_MS = 32000;
   localparam int unsigned BATT_RUN_MS = 60000;
   localparam int unsigned CABLE_STABLE_MS = 3000;
   localparam int unsigned SHDN_MS = 35000;
   localparam int unsigned BLINK_CABLE_MS = 400;
   localparam int unsigned BLINK_BATT_MS = 2000;
   localparam int unsigned BLINK_LOAD_MS = 200;
   localparam int unsigned PULSE_HALF_MS = 100;
   localparam int unsigned REPLY_TMO_MS = 1000;
   localparam int unsigned TMR_W = 17;
   // Two-wire command and status addressing
   localparam logic [6:0] CMD_TARGET = 7'h6b;
   localparam logic [7:0] CMD_BOOT_REG = 8'h00;
   localparam logic [7:0] CMD_BOOT_VAL = 8'hff;
   localparam logic [6:0] STAT_TARGET = 7'h69;
   localparam logic [7:0] STAT_FW_REG = 8'h26;
   // Arbitrary neutral firmware version code
   localparam logic [7:0] FW_VERSION_DEF = 8'h01;

   typedef enum logic [2:0] {
      M_CHECK = 3'b000,
      M_BOOT_WAIT = 3'b001,
      M_BOOT_LOAD = 3'b010,
      M_OFF = 3'b011,
      M_RUN = 3'b100,
      M_SHDN = 3'b101
   } mode_t;

   typedef enum logic [1:0] {
      K_IDLE = 2'b00,
      K_RST = 2'b01,
      K_BOTH = 2'b10,
      K_SHUT = 2'b11
   } key_t;
endpackage : boot_supervisor_pkg

// ---- design/ms_tick_gen.sv ----
// Divider that makes a one-cycle enable pulse once per tick period
module ms_tick_gen #(
   parameter int unsigned DIV = 10000
) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   output logic o_tick
);
   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } tick_state_t;

   tick_state_t q, d;

   always_comb begin
      d = q;
      d.tick = 1'b0;
      if (q.cnt == 16'(DIV - 1)) begin
         d.cnt = 16'h0000;
         d.tick = 1'b1;
      end else begin
         d.cnt = q.cnt + 16'h0001;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_tick = q.tick;
endmodule : ms_tick_gen

// ---- dv/supervisor_props.sv ----
// Port checker for the boot and power supervisor
module supervisor_props
   import boot_supervisor_pkg::*;
#(
   parameter int unsigned TICK_DIV = 10,
   parameter int unsigned WDOG_TICKS = 32,
   parameter int unsigned STABLE_TICKS = 3,
   parameter logic [7:0] FW_VERSION = 8'h01
) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_cmd_wr,
   input wire logic i_cmd_rd,
   input wire logic [6:0] i_cmd_target,
   input wire logic [7:0] i_cmd_reg,
   input wire logic [7:0] i_cmd_wdata,
   input wire logic i_cable_ok,
   input wire logic o_cmd_rvalid,
   input wire logic [7:0] o_cmd_rdata,
   input wire logic o_host_pwr_en,
   input wire logic o_batt_en,
   input wire logic o_led_orange,
   input wire logic o_led_blue,
   input wire logic o_led_status,
   input wire logic o_boot_mode
);
   logic [19:0] wait_q;
   logic [19:0] cable_q;
   logic rd_hit;
   logic wr_hit;
   assign rd_hit = i_cmd_rd && i_cmd_target == STAT_TARGET && i_cmd_reg == STAT_FW_REG;
   assign wr_hit = i_cmd_wr && i_cmd_target == CMD_TARGET && i_cmd_reg == CMD_BOOT_REG
      && i_cmd_wdata == CMD_BOOT_VAL;
   // Counters free-run wide enough for the whole run, so no saturation is needed
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wait_q <= '0;
         cable_q <= '0;
      end else begin
         wait_q <= (o_boot_mode && o_led_orange) ? wait_q + 20'h1 : 20'h0;
         cable_q <= i_cable_ok ? cable_q + 20'h1 : 20'h0;
      end
   end
   default clocking @(posedge i_ref_clk);
   endclocking
   default disable iff (i_sys_rst);
   boot_no_batt_a: assert property (o_boot_mode |-> !o_batt_en)
      else $error("battery on in bootloader");
   one_user_led_a: assert property (o_boot_mode && $past(o_boot_mode)
      |-> o_led_orange != o_led_blue)
      else $error("user leds wrong in bootloader");
   version_read_a: assert property (rd_hit
      |=> o_cmd_rvalid && o_cmd_rdata == FW_VERSION)
      else $error("version read not answered");
   rvalid_cause_a: assert property (o_cmd_rvalid |-> $past(rd_hit))
      else $error("read answer without read");
   boot_request_a: assert property (wr_hit && !o_boot_mode
      |-> ##2 o_boot_mode && o_led_orange)
      else $error("boot request not taken");
   boot_led_on_a: assert property ($rose(o_host_pwr_en) |-> ##2 o_led_status [*8])
      else $error("status led not lit at power up");
   off_no_batt_a: assert property (!o_host_pwr_en |-> !o_batt_en)
      else $error("battery on with host off");
   cable_stable_a: assert property ($fell(o_batt_en) && o_host_pwr_en
      |-> cable_q >= (STABLE_TICKS - 1) * TICK_DIV)
      else $error("battery released too early");
   wdog_limit_a: assert property (wait_q <= (WDOG_TICKS + 2) * TICK_DIV)
      else $error("bootloader wait too long");
endmodule : supervisor_props

bind boot_supervisor supervisor_props #(.TICK_DIV(TICK_DIV), .WDOG_TICKS(WDOG_TICKS),
   .STABLE_TICKS(STABLE_TICKS), .FW_VERSION(FW_VERSION)) supervisor_props_inst (.i_ref_clk,
   .i_sys_rst, .i_cmd_wr, .i_cmd_rd, .i_cmd_target, .i_cmd_reg, .i_cmd_wdata, .i_cable_ok,
   .o_cmd_rvalid, .o_cmd_rdata, .o_host_pwr_en, .o_batt_en, .o_led_orange, .o_led_blue,
   .o_led_status, .o_boot_mode);

// ---- dv/host_model.sv ----
// Host computer stand-in that echoes the supervisor pulse train
module host_model (
   input wire logic i_ref_clk,
   input wire logic i_pulse,
   input wire logic i_pwr_en,
   input wire logic i_echo_en,
   input wire logic i_slow,
   output logic o_reply
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] echo_q = 2'b00;
   always @(posedge i_ref_clk) begin
      echo_q <= {echo_q[0], i_pulse};
   end
   // An unpowered host leaves its reply line low
   assign o_reply = i_pwr_en && i_echo_en && echo_q[i_slow];
endmodule : host_model

// ---- dv/tb.sv ----
// Self-checking bench for the boot and power supervisor
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import boot_supervisor_pkg::*;
   localparam int TD = 10;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [6:0] tgt = 7'h00;
   logic [7:0] rg = 8'h00;
   logic [7:0] wd = 8'h00;
   logic rkey = 1'b0;
   logic skey = 1'b0;
   logic up = 1'b0;
   logic done = 1'b0;
   logic cable = 1'b1;
   logic cfg = 1'b0;
   logic tog = 1'b0;
   logic slow = 1'b0;
   logic echo = 1'b1;
   logic reply, pulse, pwr, batt, orange, blue, status, boot, rvalid;
   logic [7:0] rdata;
   int failures = 0;
   int tests_run = 0;
   int cyc = 0;
   // Reply timeout shortened but kept above the pulse half period
   boot_supervisor #(.TICK_DIV(TD), .WDOG_TICKS(32), .BATT_TICKS(60), .STABLE_TICKS(3),
      .SHDN_TICKS(35), .REPLY_TICKS(150)) boot_supervisor_inst (.i_ref_clk(clk),
      .i_sys_rst(rst),
      .i_cmd_wr(wr), .i_cmd_rd(rd), .i_cmd_target(tgt), .i_cmd_reg(rg), .i_cmd_wdata(wd),
      .o_cmd_rvalid(rvalid), .o_cmd_rdata(rdata), .i_reset_key(rkey), .i_shutdown_key(skey),
      .i_upload_active(up), .i_upload_done(done), .i_cable_ok(cable), .i_toggle_cfg(cfg),
      .i_power_toggle(tog), .i_host_reply(reply), .o_host_pulse(pulse), .o_host_pwr_en(pwr),
      .o_batt_en(batt), .o_led_orange(orange), .o_led_blue(blue), .o_led_status(status),
      .o_boot_mode(boot));
   host_model host_model_inst (.i_ref_clk(clk), .i_pulse(pulse), .i_pwr_en(pwr),
      .i_echo_en(echo), .i_slow(slow), .o_reply(reply));
   initial begin
      forever #50 clk = ~clk;
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : check
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done
   // Hang guard sized for the two long blink measurements
   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         failures++;
         test_done();
      end
   end
   function automatic logic sig(input int w);
      case (w)
         0: return boot;
         3: return status;
         4: return pwr;
         default: return batt;
      endcase
   endfunction : sig
   task automatic wait_for(input int w, input logic v, input int lim, output int t);
      t = 0;
      #1;
      while (sig(w) !== v && t < lim) begin
         @(posedge clk);
         #1;
         t++;
      end
   endtask : wait_for
   task automatic period(output int p);
      int t;
      wait_for(3, 1'b0, 30000, t);
      wait_for(3, 1'b1, 30000, t);
      wait_for(3, 1'b0, 30000, p);
      wait_for(3, 1'b1, 30000, t);
      p += t;
   endtask : period
   task automatic t_version();
      @(posedge clk);
      rd <= 1'b1;
      tgt <= STAT_TARGET;
      rg <= STAT_FW_REG;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check("rvalid", rvalid, 1'b1);
      check("version", rdata, FW_VERSION_DEF);
      @(posedge clk);
      #1;
      check("rvalid end", rvalid, 1'b0);
   endtask : t_version
   task automatic t_boot();
      int t;
      @(posedge clk);
      wr <= 1'b1;
      tgt <= CMD_TARGET;
      rg <= CMD_BOOT_REG;
      wd <= CMD_BOOT_VAL;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
      #1;
      check("boot", boot, 1'b1);
      check("orange", orange, 1'b1);
      check("batt", batt, 1'b0);
      @(posedge clk);
      up <= 1'b1;
      @(posedge clk);
      up <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check("blue", {orange, blue}, 2'b01);
      wait_for(3, ~status, 150 * TD, t);
      check("load blink", t < 150 * TD, 1'b1);
      @(posedge clk);
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
      wait_for(0, 1'b0, 5, t);
      check("leave boot", boot, 1'b0);
   endtask : t_boot
   task automatic t_keys();
      int t;
      @(posedge clk);
      rkey <= 1'b1;
      @(posedge clk);
      skey <= 1'b1;
      @(posedge clk);
      rkey <= 1'b0;
      @(posedge clk);
      skey <= 1'b0;
      wait_for(0, 1'b1, 6, t);
      check("key orange", orange, 1'b1);
      wait_for(0, 1'b0, 40 * TD, t);
      check("watchdog", t >= 31 * TD && t <= 34 * TD, 1'b1);
   endtask : t_keys
   task automatic t_no_reply();
      int t;
      @(posedge clk);
      echo <= 1'b0;
      repeat (300 * TD) @(posedge clk);
      #1;
      check("reply lost", status, 1'b1);
      wait_for(3, 1'b0, 250 * TD, t);
      check("steady lit", t, 250 * TD);
      @(posedge clk);
      echo <= 1'b1;
      wait_for(3, 1'b0, 400 * TD, t);
      check("reply back", status, 1'b0);
   endtask : t_no_reply
   task automatic t_battery();
      int t;
      @(posedge clk);
      slow <= 1'b1;
      cable <= 1'b0;
      wait_for(5, 1'b1, 5, t);
      check("on batt", {pwr, batt}, 2'b11);
      @(posedge clk);
      cable <= 1'b1;
      wait_for(5, 1'b0, 10 * TD, t);
      check("settle", t >= 2 * TD && t <= 5 * TD, 1'b1);
      @(posedge clk);
      cable <= 1'b0;
      repeat (63 * TD) @(posedge clk);
      #1;
      check("shdn req", pulse, 1'b1);
      wait_for(4, 1'b0, 40 * TD, t);
      check("shdn time", t >= 29 * TD && t <= 35 * TD, 1'b1);
      check("batt off", batt, 1'b0);
   endtask : t_battery
   task automatic t_toggle();
      int t;
      @(posedge clk);
      slow <= 1'b0;
      tog <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check("no cfg", pwr, 1'b0);
      @(posedge clk);
      tog <= 1'b0;
      cfg <= 1'b1;
      @(posedge clk);
      tog <= 1'b1;
      wait_for(4, 1'b1, 5, t);
      check("toggle on", {pwr, batt}, 2'b11);
      @(posedge clk);
      #1;
      check("boot led", status, 1'b1);
      period(t);
      check("batt blink", t >= 1998 * TD && t <= 2002 * TD, 1'b1);
      @(posedge clk);
      tog <= 1'b0;
      repeat (20 * TD) @(posedge clk);
      #1;
      check("toggle shdn", pulse, 1'b1);
      check("shdn led", status, 1'b1);
      repeat (5 * TD) @(posedge clk);
      #1;
      check("steady", status, 1'b1);
      wait_for(4, 1'b0, 20 * TD, t);
      check("toggle off", {pwr, batt}, 2'b00);
   endtask : t_toggle
   initial begin
      int t;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check("run", {pwr, orange}, 2'b10);
      t_version();
      t_boot();
      t_keys();
      period(t);
      check("cable blink", t >= 398 * TD && t <= 402 * TD, 1'b1);
      t_no_reply();
      t_battery();
      t_toggle();
      @(posedge clk);
      cable <= 1'b1;
      wait_for(4, 1'b1, 10 * TD, t);
      check("host back", {pwr, batt}, 2'b10);
      test_done();
   end
endmodule : tb
